// *** pmic_sm_pkg.sv ***
// Overview of operation
// - ACTIVE needs supply plus first power-on reset
// - SPI command moves ACTIVE to DISABLED/LOCKED
// - enable or fault expiry enters ACTIVE with reset
// - hard-reset fault moves ACTIVE to FAULT
// - third hard-reset fault goes FAULT to LOCKED
// - fault-count LOCKED entry needs edge-mode or low enable
// - rail events map to fault, reset, interrupt
// - watchdog and io supply events mapping
// - first init expiry resets, stays ACTIVE
// - second init expiry enters FAULT
// - band gap warning only interrupts
// - band gap fault enters FAULT
// - overtemp warnings interrupt, faults enter FAULT
// - internal supply fault switches off, restarts
// - init timeout nominal 600 ms
// - fault time 20/1000 ms, transition fast
// - SPI state request passes FAULT 20 ms
// - FAULT turns regulators off, reset low
// - repeated soft-reset fault escalates, except overflow
package pmic_sm_pkg;

	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned INIT_TIME_MS    = 600;
	localparam int unsigned FAULT_TIME_MS   = 20;
	localparam int unsigned FAULT_TSD_MS    = 1000;
	localparam int unsigned TRANS_TIME_US   = 100;
	localparam int unsigned INIT_CYCLES     = CLK_HZ / 1000 * INIT_TIME_MS;
	localparam int unsigned FAULT_CYCLES    = CLK_HZ / 1000 * FAULT_TIME_MS;
	localparam int unsigned FAULT_TSD_CYCLES = CLK_HZ / 1000 * FAULT_TSD_MS;
	localparam int unsigned TRANS_CYCLES    = CLK_HZ / 1000000 * TRANS_TIME_US;
	localparam int unsigned RST_PULSE_CYCLES = 16;
	localparam int unsigned HARD_LOCK_COUNT = 3;
	localparam int unsigned TIMER_W         = 32;

	typedef enum logic [2:0] {
		ST_UNPOWERED = 3'b000,
		ST_ACTIVE    = 3'b001,
		ST_FAULT     = 3'b011,
		ST_LOCKED    = 3'b010,
		ST_DISABLED  = 3'b110
	} pmic_state_e;

	// one bit per supervised condition, level or pulse from monitors
	typedef struct packed {
		logic mainBuckOv;
		logic mainBuckUv;
		logic mainBuckStg;
		logic coreBuckOv;
		logic coreBuckUv;
		logic coreBuckStg;
		logic canBoostOv;
		logic canBoostUv;
		logic canBoostStg;
		logic firstMonitorOv;
		logic firstMonitorUv;
		logic firstMonitorStg;
		logic secondMonitorOv;
		logic secondMonitorUv;
		logic secondMonitorStg;
		logic ioSupplyOv;
		logic ioSupplyUv;
		logic ioSupplyStg;
		logic wdCountInc;
		logic wdOverflow;
		logic bandGapWarn;
		logic bandGapFault;
		logic mainBuckOtWarn;
		logic coreBuckOtWarn;
		logic monitorOtWarn;
		logic mainBuckOtFault;
		logic coreBuckOtFault;
		logic monitorOtFault;
	} pmic_events_s;

	typedef enum logic [1:0] {
		REQ_NONE     = 2'b00,
		REQ_DISABLED = 2'b01,
		REQ_LOCKED   = 2'b10
	} spi_req_e;

endpackage

// *** event_classifier.sv ***
module event_classifier
	import pmic_sm_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic         active,
	input  wire pmic_events_s ev,
	output logic              hardFault,
	output logic              thermalFault,
	output logic              softReset,
	output logic              interruptReq
);

	logic [3:0] seen_q;
	logic [3:0] seen_d;
	logic [3:0] softNow;

	// non-repeatable soft-reset causes (repeat is hard fault): main, core, first monitor, io undervolt
	assign softNow = {ev.mainBuckUv, ev.coreBuckUv,
		ev.firstMonitorUv, ev.ioSupplyUv};

	always_comb begin
		thermalFault = ev.mainBuckOtFault | ev.coreBuckOtFault
			| ev.monitorOtFault;
		hardFault = ev.mainBuckOv | ev.mainBuckStg | ev.coreBuckOv
			| ev.coreBuckStg | ev.canBoostOv | ev.canBoostStg
			| ev.firstMonitorOv | ev.firstMonitorStg;
		hardFault = hardFault | ev.ioSupplyOv | ev.ioSupplyStg;
		hardFault = hardFault | ev.bandGapFault | thermalFault;
		hardFault = hardFault | (|(softNow & seen_q));
		softReset = (|(softNow & ~seen_q)) | ev.wdOverflow;
		interruptReq = ev.canBoostUv | ev.secondMonitorOv
			| ev.secondMonitorUv | ev.secondMonitorStg
			| ev.wdCountInc | ev.bandGapWarn
			| ev.mainBuckOtWarn | ev.coreBuckOtWarn
			| ev.monitorOtWarn;
		seen_d = active ? (seen_q | softNow) : 4'h0;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			seen_q <= 4'h0;
		end else begin
			seen_q <= seen_d;
		end
	end

endmodule

// *** pmic_state_machine.sv ***
module pmic_state_machine
	import pmic_sm_pkg::*;
#(
	parameter int unsigned INIT_CNT  = INIT_CYCLES,
	parameter int unsigned FAULT_CNT = FAULT_CYCLES,
	parameter int unsigned TSD_CNT   = FAULT_TSD_CYCLES
)(
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic         supplyGood,
	input  wire logic         porEvent,
	input  wire logic         internalSupplyFault,
	input  wire logic         enableInput,
	input  wire logic         enableEdgeMode,
	input  wire spi_req_e     spiStateReq,
	input  wire logic         spiValid,
	input  wire logic         wdServiced,
	input  wire pmic_events_s events,
	output logic              regulatorsOn,
	output logic              mcuResetOutN,
	output logic              interruptOut,
	output pmic_state_e       stateOut
);

	////////////////////////////////////////////////////////////////////////
	pmic_state_e       state_q;
	pmic_state_e       state_d;
	spi_req_e          pend_q;
	spi_req_e          pend_d;
	logic [TIMER_W-1:0] timer_q;
	logic [TIMER_W-1:0] timer_d;
	logic [TIMER_W-1:0] rstCnt_q;
	logic [TIMER_W-1:0] rstCnt_d;
	logic [TIMER_W-1:0] initCnt_q;
	logic [TIMER_W-1:0] initCnt_d;
	logic               initRun_q;
	logic               initRun_d;
	logic               initErr_q;
	logic               initErr_d;
	logic               spiSeen_q;
	logic               spiSeen_d;
	logic               wdSeen_q;
	logic               wdSeen_d;
	logic [1:0]         hardCnt_q;
	logic [1:0]         hardCnt_d;
	logic               enaPrev_q;
	logic               enaPrev_d;
	logic               regOn_q;
	logic               regOn_d;
	logic               rstN_q;
	logic               rstN_d;
	logic               irq_q;
	logic               irq_d;

	logic hardFault;
	logic thermalFault;
	logic softReset;
	logic interruptReq;
	logic enableEvent;

	event_classifier u_class (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.active       (state_q == ST_ACTIVE),
		.ev           (events),
		.hardFault    (hardFault),
		.thermalFault (thermalFault),
		.softReset    (softReset),
		.interruptReq (interruptReq)
	);

	function automatic logic [TIMER_W-1:0] cnt(input int unsigned n);
		cnt = TIMER_W'(n);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// enable event: rising edge in edge mode, high level otherwise
	assign enableEvent = enableEdgeMode ? (enableInput & ~enaPrev_q)
		: enableInput;

	always_comb begin
		state_d   = state_q;
		pend_d    = pend_q;
		timer_d   = timer_q;
		rstCnt_d  = rstCnt_q;
		initCnt_d = initCnt_q;
		initRun_d = initRun_q;
		initErr_d = initErr_q;
		spiSeen_d = spiSeen_q | spiValid;
		wdSeen_d  = wdSeen_q | wdServiced;
		hardCnt_d = hardCnt_q;
		enaPrev_d = enableInput;
		irq_d     = 1'b0;

		// reset pulse countdown; init timer starts on reset release
		if (rstCnt_q != '0) begin
			rstCnt_d = rstCnt_q - 1'b1;
			if (rstCnt_q == cnt(1) && state_q == ST_ACTIVE) begin
				initRun_d = 1'b1;
				initCnt_d = cnt(INIT_CNT);
				spiSeen_d = spiValid;
				wdSeen_d  = wdServiced;
			end
		end

		if (initRun_q && spiSeen_q && wdSeen_q) begin
			initRun_d = 1'b0;
		end

		case (state_q)
			ST_UNPOWERED: begin
				if (supplyGood && porEvent
						&& !internalSupplyFault) begin
					state_d  = ST_ACTIVE;
					rstCnt_d = cnt(RST_PULSE_CYCLES);
				end
			end
			ST_ACTIVE: begin
				irq_d = interruptReq;
				if (internalSupplyFault) begin
					state_d   = ST_UNPOWERED;
					initRun_d = 1'b0;
				end else if (hardFault) begin
					state_d   = ST_FAULT;
					timer_d   = thermalFault ? cnt(TSD_CNT)
						: cnt(FAULT_CNT);
					initRun_d = 1'b0;
					if (hardCnt_q != 2'(HARD_LOCK_COUNT)) begin
						hardCnt_d = hardCnt_q + 1'b1;
					end
				end else if (initRun_q && !(spiSeen_q && wdSeen_q)
						&& initCnt_q == cnt(1)) begin
					initRun_d = 1'b0;
					if (initErr_q) begin
						state_d   = ST_FAULT;
						timer_d   = cnt(FAULT_CNT);
						initErr_d = 1'b0;
						if (hardCnt_q != 2'(HARD_LOCK_COUNT)) begin
							hardCnt_d = hardCnt_q + 1'b1;
						end
					end else begin
						initErr_d = 1'b1;
						rstCnt_d  = cnt(RST_PULSE_CYCLES);
					end
				end else if (spiValid && spiStateReq != REQ_NONE) begin
					state_d   = ST_FAULT;
					pend_d    = spiStateReq;
					timer_d   = cnt(FAULT_CNT);
					initRun_d = 1'b0;
				end else if (softReset) begin
					rstCnt_d = cnt(RST_PULSE_CYCLES);
				end
				if (initRun_q && initCnt_q != '0) begin
					initCnt_d = initCnt_q - 1'b1;
				end
			end
			ST_FAULT: begin
				if (internalSupplyFault) begin
					state_d = ST_UNPOWERED;
					pend_d  = REQ_NONE;
				end else if (pend_q == REQ_NONE
						&& hardCnt_q == 2'(HARD_LOCK_COUNT)
						&& (enableEdgeMode || !enableInput)) begin
					state_d   = ST_LOCKED;
					hardCnt_d = 2'd0;
				end else if (timer_q > cnt(1)) begin
					timer_d = timer_q - 1'b1;
				end else if (pend_q == REQ_LOCKED) begin
					state_d   = ST_LOCKED;
					pend_d    = REQ_NONE;
					hardCnt_d = 2'd0;
				end else if (pend_q == REQ_DISABLED) begin
					state_d   = ST_DISABLED;
					pend_d    = REQ_NONE;
					hardCnt_d = 2'd0;
				end else if (hardCnt_q != 2'(HARD_LOCK_COUNT)) begin
					state_d  = ST_ACTIVE;
					rstCnt_d = cnt(RST_PULSE_CYCLES);
				end
			end
			ST_LOCKED, ST_DISABLED: begin
				initErr_d = 1'b0;
				if (internalSupplyFault) begin
					state_d = ST_UNPOWERED;
				end else if (enableEvent) begin
					state_d  = ST_ACTIVE;
					rstCnt_d = cnt(RST_PULSE_CYCLES);
				end
			end
			default: begin
				state_d = ST_UNPOWERED;
			end
		endcase

		// outputs follow next state so they settle with the transition
		regOn_d = (state_d == ST_ACTIVE);
		rstN_d  = (state_d == ST_ACTIVE) && (rstCnt_d == '0);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q   <= ST_UNPOWERED;
			pend_q    <= REQ_NONE;
			timer_q   <= '0;
			rstCnt_q  <= '0;
			initCnt_q <= '0;
			initRun_q <= 1'b0;
			initErr_q <= 1'b0;
			spiSeen_q <= 1'b0;
			wdSeen_q  <= 1'b0;
			hardCnt_q <= 2'd0;
			enaPrev_q <= 1'b0;
			regOn_q   <= 1'b0;
			rstN_q    <= 1'b0;
			irq_q     <= 1'b0;
		end else begin
			state_q   <= state_d;
			pend_q    <= pend_d;
			timer_q   <= timer_d;
			rstCnt_q  <= rstCnt_d;
			initCnt_q <= initCnt_d;
			initRun_q <= initRun_d;
			initErr_q <= initErr_d;
			spiSeen_q <= spiSeen_d;
			wdSeen_q  <= wdSeen_d;
			hardCnt_q <= hardCnt_d;
			enaPrev_q <= enaPrev_d;
			regOn_q   <= regOn_d;
			rstN_q    <= rstN_d;
			irq_q     <= irq_d;
		end
	end

	assign regulatorsOn = regOn_q;
	assign mcuResetOutN = rstN_q;
	assign interruptOut = irq_q;
	assign stateOut     = state_q;

endmodule

// *** pmic_sm_assertions.sv ***
module pmic_sm_checker
	import pmic_sm_pkg::*;
#(
	parameter int unsigned FAULT_CNT = FAULT_CYCLES,
	parameter int unsigned TSD_CNT   = FAULT_TSD_CYCLES
)(
	input wire logic         core_clk,
	input wire logic         nrst,
	input wire logic         supplyGood,
	input wire logic         porEvent,
	input wire logic         internalSupplyFault,
	input wire spi_req_e     spiStateReq,
	input wire logic         spiValid,
	input wire pmic_events_s events,
	input wire logic         regulatorsOn,
	input wire logic         mcuResetOutN,
	input wire logic         interruptOut,
	input wire pmic_state_e  stateOut
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [31:0] faultLen_q;
	logic [31:0] faultLen_d;
	// cycles spent in fault so far
	always_comb begin
		faultLen_d = (stateOut == ST_FAULT) ? faultLen_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge core_clk) begin
		faultLen_q <= nrst ? faultLen_d : 32'h0;
	end
	////////////////////////////////////////
	sequence s_up;
		stateOut == ST_UNPOWERED && supplyGood && porEvent && !internalSupplyFault;
	endsequence
	sequence s_leave_fault;
		stateOut == ST_FAULT ##1 stateOut == ST_ACTIVE;
	endsequence
	sequence s_hold_rst;
		!mcuResetOutN [*8];
	endsequence
	a_power_up: assert property (s_up |=> stateOut == ST_ACTIVE)
		else $error("no power-up");
	a_stay_off: assert property (stateOut == ST_UNPOWERED
		&& !(supplyGood && porEvent) |=> stateOut == ST_UNPOWERED)
		else $error("early power-up");
	a_spi_fault: assert property (stateOut == ST_ACTIVE && spiValid
		&& spiStateReq != REQ_NONE && !internalSupplyFault
		|=> stateOut == ST_FAULT)
		else $error("request skipped fault");
	a_off_outputs: assert property (stateOut != ST_ACTIVE
		|-> !regulatorsOn && !mcuResetOutN)
		else $error("outputs on outside active");
	a_hard_fault: assert property (stateOut == ST_ACTIVE
		&& !internalSupplyFault && (events.mainBuckOv || events.ioSupplyStg
		|| events.bandGapFault || events.mainBuckOtFault)
		|-> ##[1:2] stateOut == ST_FAULT)
		else $error("hard fault ignored");
	a_irq_event: assert property (stateOut == ST_ACTIVE && $onehot(events)
		&& (events.bandGapWarn || events.secondMonitorUv)
		|-> ##[1:2] interruptOut)
		else $error("no interrupt");
	a_reset_pulse: assert property ($rose(stateOut == ST_ACTIVE)
		|-> s_hold_rst)
		else $error("no reset on entry");
	a_fault_time: assert property (s_leave_fault
		|-> faultLen_q inside {FAULT_CNT, TSD_CNT})
		else $error("fault time wrong");
	a_supply_off: assert property (internalSupplyFault
		|=> stateOut == ST_UNPOWERED)
		else $error("internal supply fault ignored");
	a_soft_reset: assert property (stateOut == ST_ACTIVE
		&& (events.mainBuckUv || events.coreBuckUv || events.firstMonitorUv
		|| events.ioSupplyUv || events.wdOverflow) |=> !mcuResetOutN)
		else $error("no reset on soft fault");
endmodule
bind pmic_state_machine pmic_sm_checker #(
	.FAULT_CNT(FAULT_CNT),
	.TSD_CNT  (TSD_CNT)
) chk (.core_clk, .nrst, .supplyGood, .porEvent, .internalSupplyFault,
	.spiStateReq, .spiValid, .events, .regulatorsOn, .mcuResetOutN,
	.interruptOut, .stateOut);

// *** mcu_model.sv ***
module mcu_model
	import pmic_sm_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     mcuResetOutN,
	input  wire logic     mute,
	input  wire logic     reqGo,
	input  wire spi_req_e reqKind,
	output logic          spiValid,
	output spi_req_e      spiStateReq,
	output logic          wdServiced
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       rstSeen = 1'b0;
	logic [2:0] step    = 3'h0;
	// config frame then watchdog service after each reset release while mute is low
	always @(posedge core_clk) begin
		rstSeen <= mcuResetOutN === 1'b1;
		if (mcuResetOutN === 1'b1 && !rstSeen && !mute) begin
			step <= 3'h4;
		end else if (step != 3'h0) begin
			step <= step - 3'h1;
		end
		spiValid <= reqGo || step == 3'h2;
		spiStateReq <= reqGo ? reqKind : REQ_NONE;
		wdServiced <= step == 3'h1;
	end
endmodule

// *** tb.sv ***
module tb;
	import pmic_sm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned FCNT = 20;
	localparam int unsigned TCNT = 40;
	logic         core_clk = 1'b0;
	logic         nrst = 1'b0;
	logic         supplyGood = 1'b0;
	logic         porEvent = 1'b0;
	logic         internalSupplyFault = 1'b0;
	logic         enableInput = 1'b0;
	logic         enableEdgeMode = 1'b0;
	logic         mute = 1'b0;
	logic         reqGo = 1'b0;
	spi_req_e     reqKind = REQ_NONE;
	pmic_events_s events = '0;
	logic         spiValid, wdServiced, regulatorsOn, mcuResetOutN, interruptOut;
	spi_req_e     spiStateReq;
	pmic_state_e  stateOut;
	int           fail_count = 0;
	int           comparisons = 0;
	always #10 core_clk = ~core_clk;
	pmic_state_machine #(.INIT_CNT(50), .FAULT_CNT(FCNT), .TSD_CNT(TCNT)) uut (
		.core_clk, .nrst, .supplyGood, .porEvent, .internalSupplyFault,
		.enableInput, .enableEdgeMode, .spiStateReq, .spiValid, .wdServiced,
		.events, .regulatorsOn, .mcuResetOutN, .interruptOut, .stateOut);
	mcu_model host (.core_clk, .mcuResetOutN, .mute, .reqGo, .reqKind,
		.spiValid, .spiStateReq, .wdServiced);
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_state(input pmic_state_e st, input int bound);
		int n;
		n = 0;
		#1;
		while (stateOut !== st && n < bound) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (stateOut !== st) begin
			$display("CHECK FAILED at %0t: state wait ran out", $time);
			fail_count++;
			close_out();
		end
	endtask
	////////////////////////////////////////
	task automatic power_up();
		@(posedge core_clk);
		supplyGood <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check(stateOut, ST_UNPOWERED);
		@(posedge core_clk);
		porEvent <= 1'b1;
		wait_state(ST_ACTIVE, 4);
		check(regulatorsOn, 1'b1);
		check(mcuResetOutN, 1'b0);
		repeat (30) @(posedge core_clk);
	endtask
	task automatic irq_only(input pmic_events_s ev);
		logic seen;
		@(posedge core_clk);
		events <= ev;
		@(posedge core_clk);
		events <= '0;
		seen = 1'b0;
		repeat (3) begin
			#1;
			seen = seen | interruptOut;
			@(posedge core_clk);
		end
		#1;
		check(seen, 1'b1);
		check(stateOut, ST_ACTIVE);
	endtask
	task automatic hard_fault(input pmic_events_s ev,
			input pmic_state_e dest, input int len);
		int n;
		@(posedge core_clk);
		events <= ev;
		@(posedge core_clk);
		events <= '0;
		wait_state(ST_FAULT, 3);
		check(regulatorsOn, 1'b0);
		n = 0;
		while (stateOut === ST_FAULT && n < TCNT + 8) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(n, len);
		wait_state(dest, 1);
		check(stateOut, dest);
		check(mcuResetOutN, 1'b0);
		repeat (30) @(posedge core_clk);
	endtask
	task automatic wake();
		@(posedge core_clk);
		enableEdgeMode <= 1'b1;
		enableInput <= 1'b0;
		@(posedge core_clk);
		enableInput <= 1'b1;
		wait_state(ST_ACTIVE, 8);
		check(mcuResetOutN, 1'b0);
		repeat (30) @(posedge core_clk);
	endtask
	task automatic spi_request(input spi_req_e k, input pmic_state_e dest);
		@(posedge core_clk);
		reqKind <= k;
		reqGo <= 1'b1;
		@(posedge core_clk);
		reqGo <= 1'b0;
		wait_state(ST_FAULT, 6);
		check(stateOut, ST_FAULT);
		wait_state(dest, FCNT + 8);
		check(stateOut, dest);
	endtask
	task automatic init_timeout();
		int n;
		@(posedge core_clk);
		mute <= 1'b1;
		wake();
		n = 0;
		while (mcuResetOutN !== 1'b0 && n < 80) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(mcuResetOutN, 1'b0);
		check(stateOut, ST_ACTIVE);
		wait_state(ST_FAULT, 100);
		check(stateOut, ST_FAULT);
		@(posedge core_clk);
		mute <= 1'b0;
		wait_state(ST_ACTIVE, FCNT + 8);
	endtask
	task automatic pulse(input pmic_events_s ev);
		@(posedge core_clk);
		events <= ev;
		@(posedge core_clk);
		events <= '0;
		#1;
	endtask
	task automatic wait_release();
		int n;
		n = 0;
		while (mcuResetOutN !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (mcuResetOutN !== 1'b1) begin
			$display("CHECK FAILED at %0t: reset wait ran out", $time);
			fail_count++;
			close_out();
		end
		repeat (10) @(posedge core_clk);
	endtask
	task automatic soft_faults();
		wait_release();
		pulse('{mainBuckUv: 1'b1, default: 1'b0});
		check(mcuResetOutN, 1'b0);
		check(stateOut, ST_ACTIVE);
		wait_release();
		repeat (2) begin
			pulse('{wdOverflow: 1'b1, default: 1'b0});
			check(mcuResetOutN, 1'b0);
			check(stateOut, ST_ACTIVE);
			wait_release();
		end
		pulse('{mainBuckUv: 1'b1, default: 1'b0});
		check(stateOut, ST_FAULT);
		wait_state(ST_ACTIVE, FCNT + 8);
	endtask
	task automatic lock_wait();
		@(posedge core_clk);
		enableEdgeMode <= 1'b0;
		enableInput <= 1'b1;
		pulse('{coreBuckOv: 1'b1, default: 1'b0});
		check(stateOut, ST_FAULT);
		repeat (FCNT + 10) @(posedge core_clk);
		#1;
		check(stateOut, ST_FAULT);
		@(posedge core_clk);
		enableInput <= 1'b0;
		wait_state(ST_LOCKED, 3);
		check(stateOut, ST_LOCKED);
		@(posedge core_clk);
		enableInput <= 1'b1;
		wait_state(ST_ACTIVE, 4);
		check(mcuResetOutN, 1'b0);
		repeat (30) @(posedge core_clk);
	endtask
	task automatic internal_off();
		@(posedge core_clk);
		internalSupplyFault <= 1'b1;
		wait_state(ST_UNPOWERED, 3);
		check(regulatorsOn, 1'b0);
		repeat (5) @(posedge core_clk);
		#1;
		check(stateOut, ST_UNPOWERED);
		@(posedge core_clk);
		internalSupplyFault <= 1'b0;
		wait_state(ST_ACTIVE, 4);
		check(mcuResetOutN, 1'b0);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		power_up();
		irq_only('{bandGapWarn: 1'b1, default: 1'b0});
		irq_only('{secondMonitorUv: 1'b1, default: 1'b0});
		hard_fault('{mainBuckOv: 1'b1, default: 1'b0}, ST_ACTIVE, FCNT);
		hard_fault('{mainBuckOtFault: 1'b1, default: 1'b0}, ST_ACTIVE, TCNT);
		hard_fault('{bandGapFault: 1'b1, default: 1'b0}, ST_LOCKED, 1);
		wake();
		hard_fault('{ioSupplyStg: 1'b1, default: 1'b0}, ST_ACTIVE,
			FCNT);
		spi_request(REQ_DISABLED, ST_DISABLED);
		wake();
		spi_request(REQ_LOCKED, ST_LOCKED);
		init_timeout();
		soft_faults();
		lock_wait();
		internal_off();
		close_out();
	end
endmodule
